// [pkg/fbp_pkg.sv]
// constants and register map for the fourteen-bit pulse-width modulator
// Overview of operation
// - port select bit 0 gives the shared pin to the port (0) or modulator (1)
// - control bit 2 picks pulse-division waveform at 0, standard waveform at 1
// - control bits 1:0 pick input clock as system clock over 2, 4, 8, 16
// - conversion period 16384..131072 system clocks, minimum width 1..8 clocks
// - clock select bits are write-only and always read back as 1
// - data register holds a 14-bit high width for one waveform cycle
// - every data write is captured at once and drives all later output
package fbp_pkg;
  // register bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [15:0] OFS_PIN_SELECT = 16'hFFC8;
  localparam logic [15:0] OFS_CONTROL = 16'hFFD0;
  localparam logic [15:0] OFS_HIGH_WIDTH = 16'hFFD2;
  // field positions
  localparam int PIN_SELECT_BIT = 0;
  localparam int STYLE_BIT = 2;
  localparam int CLK_SEL_LSB = 0;
  localparam int CLK_SEL_W = 2;
  // reset values
  localparam logic [7:0] PIN_SELECT_RST = 8'h00;
  localparam logic [2:0] CONTROL_RST = 3'h0;
  localparam logic [13:0] HIGH_WIDTH_RST = 14'h0000;
  // read-back of the control register: clock select bits read as 1
  localparam logic [15:0] CONTROL_READ = 16'h0003;
  // waveform geometry
  localparam int WIDTH_BITS = 14;
  localparam int SUB_BITS = 6;
  localparam int POS_BITS = WIDTH_BITS - SUB_BITS;
  // prescaler width covers division by 16
  localparam int PRESC_W = 4;
  // timing: system clock and the unit of the modulation counter
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
  localparam int PERIOD_UNITS = 16384;
  // waveform style codes
  localparam logic STYLE_PULSE_DIV = 1'b0;
  localparam logic STYLE_STANDARD = 1'b1;
endpackage

// [hw/fbp_pwm.sv]
// fourteen-bit pulse-width modulator with its shared port pin
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module fbp_pwm
  import fbp_pkg::*;
#(
  parameter int HIGH_WIDTH_W = WIDTH_BITS
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // general-purpose port bit logic
  input wire logic shared_port_bit_data_in,
  input wire logic shared_port_bit_dir_in,
  output logic shared_port_bit_value_out,
  // shared pin, enable low while driving
  input wire logic modulator_output_pin_in,
  output logic modulator_output_pin_out,
  output logic modulator_output_pin_oe_n_out,
  // status
  output logic modulator_level_out,
  output logic period_start_out
);

  // registers
  logic [7:0] port_pin_function_select;
  logic waveform_style_select;
  logic clock_select_high;
  logic clock_select_low;
  logic [HIGH_WIDTH_W-1:0] modulator_high_width_data;
  logic [PRESC_W-1:0] presc;
  logic [WIDTH_BITS-1:0] unit_cnt;
  logic [2:0] pin_sync;
  logic pin_value;

  // reverse six bits so that extra units spread evenly over sub-periods
  function automatic logic [SUB_BITS-1:0] bit_rev(input logic [SUB_BITS-1:0] v);
    logic [SUB_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < SUB_BITS; i++) begin
      r[i] = v[SUB_BITS-1-i];
    end
    return r;
  endfunction

  // address decode
  wire sel_pin = (reg_addr_in == OFS_PIN_SELECT);
  wire sel_ctl = (reg_addr_in == OFS_CONTROL);
  wire sel_dat = (reg_addr_in == OFS_HIGH_WIDTH);
  wire wr_pin = reg_wr_in && sel_pin;
  wire wr_ctl = reg_wr_in && sel_ctl;
  wire wr_dat = reg_wr_in && sel_dat;

  // read mux; data register is write-only and reads zero
  // clock bits read one
  wire [DATA_W-1:0] next_rdata = sel_pin ? {8'h00, port_pin_function_select} :
                                 sel_ctl ? CONTROL_READ : 16'h0000;

  // register writes
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      port_pin_function_select <= PIN_SELECT_RST;
      {waveform_style_select, clock_select_high, clock_select_low} <= CONTROL_RST;
    end else begin
      if (wr_pin) begin
        port_pin_function_select <= reg_wdata_in[7:0];
      end
      if (wr_ctl) begin
        waveform_style_select <= reg_wdata_in[STYLE_BIT];
        {clock_select_high, clock_select_low} <= reg_wdata_in[CLK_SEL_LSB +: CLK_SEL_W];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      modulator_high_width_data <= HIGH_WIDTH_RST;
    end else if (wr_dat) begin
      modulator_high_width_data <= reg_wdata_in[HIGH_WIDTH_W-1:0];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? next_rdata : 16'h0000;
    end
  end

  // prescaler: input clock is system/2..16, the counting unit half of it
  wire [1:0] clk_code = {clock_select_high, clock_select_low};
  wire [PRESC_W-1:0] unit_mask = PRESC_W'((1 << clk_code) - 1);
  wire unit_en = ((presc & unit_mask) == unit_mask);
  wire [PRESC_W-1:0] next_presc = presc + 4'h1;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      presc <= 4'h0;
    end else begin
      presc <= next_presc;
    end
  end

  // period counter, 16384 units per conversion period
  wire [WIDTH_BITS-1:0] next_unit_cnt = unit_cnt + 14'h0001;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      unit_cnt <= 14'h0000;
    end else if (unit_en) begin
      unit_cnt <= next_unit_cnt;
    end
  end

  // waveform decode
  wire [SUB_BITS-1:0] sub_idx = unit_cnt[WIDTH_BITS-1:POS_BITS];
  wire [POS_BITS-1:0] sub_pos = unit_cnt[POS_BITS-1:0];
  wire [POS_BITS-1:0] base_w = modulator_high_width_data[WIDTH_BITS-1:SUB_BITS];
  wire extra = (bit_rev(sub_idx) < modulator_high_width_data[SUB_BITS-1:0]);
  wire [POS_BITS:0] sub_w = {1'b0, base_w} + {{POS_BITS{1'b0}}, extra};
  wire level_div = ({1'b0, sub_pos} < sub_w);
  wire level_std = (unit_cnt < modulator_high_width_data);
  wire next_level = (waveform_style_select == STYLE_STANDARD) ? level_std : level_div;
  wire next_start = unit_en && (next_unit_cnt == 14'h0000);

  wire pin_is_mod = port_pin_function_select[PIN_SELECT_BIT];
  wire next_pin = pin_is_mod ? next_level : shared_port_bit_data_in;
  wire next_oe_n = pin_is_mod ? 1'b0 : ~shared_port_bit_dir_in;

  // registered outputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      modulator_level_out <= 1'b0;
      period_start_out <= 1'b0;
      modulator_output_pin_out <= 1'b0;
      modulator_output_pin_oe_n_out <= 1'b1;
    end else begin
      modulator_level_out <= next_level;
      period_start_out <= next_start;
      modulator_output_pin_out <= next_pin;
      modulator_output_pin_oe_n_out <= next_oe_n;
    end
  end

  // pin input synchroniser, value taken when stages two and three agree
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin_sync <= 3'h0;
      pin_value <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], modulator_output_pin_in};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_value <= pin_sync[2];
      end
    end
  end

  assign shared_port_bit_value_out = pin_value;

endmodule

// [verification/fbp_pwm_properties.sv]
// assertion checker bound to the pulse-width modulator ports
`timescale 1ns/1ps
module fbp_pwm_properties
  import fbp_pkg::*;
(
  // clock, reset and register port
  input logic core_clk_in, rst_in, reg_wr_in, reg_rd_in,
  input logic [ADDR_W-1:0] reg_addr_in,
  input logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out,
  // pin and waveform
  input logic shared_port_bit_data_in, shared_port_bit_dir_in,
  input logic modulator_output_pin_out, modulator_output_pin_oe_n_out,
  input logic modulator_level_out, period_start_out
);
  logic [7:0] sel;
  logic [13:0] wd;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // shadow of the select and width registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sel <= 8'h00;
      wd <= 14'h0000;
    end else if (reg_wr_in && reg_addr_in == OFS_PIN_SELECT) sel <= reg_wdata_in[7:0];
    else if (reg_wr_in && reg_addr_in == OFS_HIGH_WIDTH) wd <= reg_wdata_in[13:0];
  end
  property p_ctl; reg_rd_in && reg_addr_in == OFS_CONTROL |=> reg_rdata_out == CONTROL_READ; endproperty
  a_ctl: assert property (p_ctl) else $error("control read");
  property p_dat; reg_rd_in && reg_addr_in == OFS_HIGH_WIDTH |=> reg_rdata_out == 16'h0000; endproperty
  a_dat: assert property (p_dat) else $error("width read");
  property p_sel; reg_rd_in && reg_addr_in == OFS_PIN_SELECT |=> reg_rdata_out == {8'h00, $past(sel)}; endproperty
  a_sel: assert property (p_sel) else $error("select read");
  property p_drv; sel[0] |=> !modulator_output_pin_oe_n_out && modulator_output_pin_out == modulator_level_out;
  endproperty
  a_drv: assert property (p_drv) else $error("modulator pin");
  property p_port; !sel[0] |=> modulator_output_pin_out == $past(shared_port_bit_data_in)
    && modulator_output_pin_oe_n_out == !$past(shared_port_bit_dir_in); endproperty
  a_port: assert property (p_port) else $error("port pin");
  property p_zero; wd == 14'h0000 |=> !modulator_level_out; endproperty
  a_zero: assert property (p_zero) else $error("zero width");
  property p_pulse; period_start_out |=> !period_start_out [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("period pulse");
  property p_head; period_start_out && wd != 14'h0000 |=> modulator_level_out; endproperty
  a_head: assert property (p_head) else $error("period head");
endmodule
bind fbp_pwm fbp_pwm_properties u_prop (.*);

// [verification/fbp_pwm_test.sv]
// self-checking bench for the pulse-width modulator
`timescale 1ns/1ps
module fbp_pwm_test;
  import fbp_pkg::*;
  logic clk, rst = 1, wr = 0, rd = 0, rd_d = 0, pd = 0, pdir = 0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic val, pout, oe_n, lvl, ps;
  logic [15:0] q[$];
  int error_cnt = 0, num_checks = 0;
  // pulled-up pin level, driven by the block when enabled
  wire pin = oe_n ? 1'b1 : pout;
  fbp_pwm uut (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .shared_port_bit_data_in(pd),
    .shared_port_bit_dir_in(pdir), .shared_port_bit_value_out(val), .modulator_output_pin_in(pin),
    .modulator_output_pin_out(pout), .modulator_output_pin_oe_n_out(oe_n),
    .modulator_level_out(lvl), .period_start_out(ps));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wreg(input logic [15:0] a, d);
    @(posedge clk); wr <= 1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 0;
  endtask
  task automatic rreg(input logic [15:0] a, e);
    @(posedge clk); rd <= 1; addr <= a; q.push_back(e);
    @(posedge clk); rd <= 0;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk(rdata, q.pop_front());
    rd_d <= rd;
  end
  // one period between start pulses, counting high cycles
  task automatic meas(output int per, hi);
    per = 0; hi = 0;
    do @(negedge clk); while (ps !== 1);
    do begin @(negedge clk); per++; hi += (lvl === 1); end while (ps !== 1);
  endtask
  task automatic pulse(output int w, g);
    w = 0; g = 0;
    while (lvl !== 0) @(negedge clk);
    while (lvl !== 1) @(negedge clk);
    while (lvl === 1) begin w++; @(negedge clk); end
    while (lvl !== 1) begin g++; @(negedge clk); end
  endtask
  task automatic results;
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    int p, h, w, g;
    logic [13:0] d;
    void'($urandom(50));
    d = 14'($urandom_range(16383, 1));
    repeat (6) @(posedge clk);
    rst <= 0; pd <= 0; pdir <= 0;
    rreg(OFS_PIN_SELECT, 16'h0000);
    // port mode, port bit not driving: pin floats to the pull-up
    repeat (4) @(negedge clk);
    chk({14'h0000, oe_n, val}, 16'h0003);
    wreg(OFS_PIN_SELECT, 16'h00A5);
    rreg(OFS_PIN_SELECT, 16'h00A5);
    rreg(OFS_CONTROL, CONTROL_READ);
    rreg(16'h0000, 16'h0000);
    rreg(OFS_HIGH_WIDTH, 16'h0000);
    @(negedge clk);
    chk({15'h0000, oe_n}, 16'h0000);
    // modulator owns the pin, zero width keeps it low
    chk({15'h0000, val}, 16'h0000);
    // standard style, system clock over 2
    wreg(OFS_HIGH_WIDTH, {2'b00, d});
    wreg(OFS_CONTROL, 16'h0004);
    meas(p, h);
    chk(16'(p), 16'h4000);
    chk(16'(h), {2'b00, d});
    // pulse-division, one unit high per sub-period, every clock code
    wreg(OFS_HIGH_WIDTH, 16'h0040);
    for (int c = 0; c < 4; c++) begin
      wreg(OFS_CONTROL, 16'(c));
      pulse(w, g);
      pulse(w, g);
      chk(16'(w), 16'(1 << c));
      chk(16'(w + g), 16'(256 << c));
    end
    results();
  end
  // cut a hang short
  initial begin
    #9_000_000;
    error_cnt++;
    results();
  end
endmodule
